/* File: verilog/wncs_pkg.sv */
// Purpose: constants for the watch-chip console store controller
// Assumes: device bytes sit in bits 9:2 of each longword access
// Notes:   device byte indices and own register offsets are fixed here
`default_nettype none
package wncs_pkg;
  // own AHB-Lite register offsets (byte addresses)
  localparam logic [7:0] A_CTRL      = 8'h00;
  localparam logic [7:0] A_STATUS    = 8'h04;
  localparam logic [7:0] A_MODE      = 8'h08;
  localparam logic [7:0] A_RAW_ADDR  = 8'h0C;
  localparam logic [7:0] A_RAW_WDATA = 8'h10;
  localparam logic [7:0] A_RAW_RDATA = 8'h14;
  localparam logic [7:0] A_SCR_ADDR  = 8'h18;
  localparam logic [7:0] A_SCR_LEN   = 8'h1C;
  localparam logic [7:0] A_TIME0     = 8'h20;
  localparam logic [7:0] A_WORD_STEP = 8'h04;
  localparam int         TIME_REGS   = 7;
  // control bits
  localparam int C_INIT  = 0;
  localparam int C_FORCE = 1;
  localparam int C_BAT   = 2;
  localparam int C_MEM   = 3;
  localparam int C_CONS  = 4;
  localparam int C_SETUP = 5;
  localparam int C_RAW   = 6;
  localparam int RAW_WRITE_BIT = 8;
  // status bits
  localparam int S_BUSY      = 0;
  localparam int S_VALID     = 1;
  localparam int S_INIT_DONE = 2;
  localparam int S_PROMPT    = 3;
  localparam int S_SCR_LOCK  = 4;
  localparam int S_REFUSED   = 5;
  // device byte indices
  localparam logic [7:0] D_TIME [TIME_REGS] = '{8'h00, 8'h02, 8'h04, 8'h06, 8'h07, 8'h08, 8'h09};
  localparam logic [7:0] D_CSRA    = 8'h0A;
  localparam logic [7:0] D_CSRB    = 8'h0B;
  localparam logic [7:0] D_CSRD    = 8'h0D;
  localparam logic [7:0] D_SCR     = 8'h0E;
  localparam logic [7:0] D_BATCHK  = 8'h1E;
  localparam logic [7:0] D_KBD     = 8'h2A;
  localparam logic [7:0] D_CONSID  = 8'h2B;
  localparam logic [7:0] D_CONSOLE_FLAGS   = 8'h2C;
  localparam logic [7:0] D_SCRLEN  = 8'h2D;
  localparam logic [7:0] D_TAPE    = 8'h31;
  // longword layout
  localparam int LW_LSB        = 2;
  localparam int LW_VALID_BIT  = 9;
  localparam int LW_KBD_PRESENT = 8;
  // watch control values
  localparam logic       CSRB_INHIBIT = 1'b1;
  localparam logic [3:0] CSRB_IRQ_OFF = 4'h0;
  localparam logic [2:0] CSRA_DIVIDER = 3'b010;
  localparam logic [3:0] CSRA_RATE    = 4'b0000;
  // stored values
  localparam logic [7:0] BAT_PAT [4] = '{8'h55, 8'hAA, 8'h33, 8'h0F};
  localparam logic [7:0] BYTE_ZERO   = 8'h00;
  localparam logic [7:0] KBD_MAX     = 8'h0F;
  localparam logic [7:0] CONS_BITMAP = 8'hB0;
  localparam logic [3:0] BAT_LAST    = 4'd11;
  localparam logic [3:0] INIT_LAST   = 4'd10;
  localparam logic [3:0] SETUP_LAST  = 4'd8;
  localparam logic [3:0] SETUP_LEN0  = 4'd4;
  typedef enum logic [2:0] {
    WNCS_NONE, WNCS_INIT, WNCS_BAT, WNCS_MEM, WNCS_CONS, WNCS_SETUP, WNCS_RAW
  } wncs_cmd_e;
  typedef enum logic [1:0] {
    WNCS_IDLE = 2'b00, WNCS_LOAD = 2'b01, WNCS_WAIT = 2'b11
  } wncs_state_e;
endpackage
`default_nettype wire

/* File: verilog/wncs_ctrl.sv */
// Purpose: host controller that brings the watch chip and its
//          battery-backed ram to a valid state on software order
// Assumes: device register port on the same clock, ack one cycle
// Notes:   software drives it over AHB-Lite
//
// Notes on behaviour
// R1 - clear validity flag means run full init
// R2 - step one: inhibit set, interrupts off
// R3 - step two: write seven time registers
// R4 - step three: divider 010, rate 0000
// R5 - step four: step-one value, inhibit cleared
// R6 - low battery: check bytes 55 AA 33 0F
// R7 - boot device: four ascii bytes, zero padded
// R8 - low battery: boot device bytes zeroed
// R9 - low battery: boot flag bytes zeroed
// R10 - keyboard variant in bits 9:2, 0..15
// R11 - memory failure: keyboard variant set zero
// R12 - prompt if keyboard absent or variant invalid; code prompts only when console type is B0
// R13 - variant ignored for serial terminal console
// R14 - console type: 0,1,2 or B0
// R15 - scratch address written once only
// R16 - temporary storage is twelve longwords
// R17 - scratch length holds page count
// R18 - tape tape_a always zero
// R19 - keyboard present is console flags bit 8
// R20 - byte in bits 9:2, rest zero
`timescale 1ns/1ps
`default_nettype none
module wncs_ctrl
  import wncs_pkg::*;
(
  // clock and reset
  input  wire logic        clk,
  input  wire logic        reset,
  input  wire logic        ce,
  // ahb-lite slave
  input  wire logic        hsel,
  input  wire logic [31:0] haddr,
  input  wire logic [1:0]  htrans,
  input  wire logic        hwrite,
  input  wire logic [2:0]  hsize,
  input  wire logic        hready,
  input  wire logic [31:0] hwdata,
  output logic             hreadyout,
  output logic [31:0]      hrdata,
  output logic             hresp,
  // watch chip register port
  output logic             dev_req,
  output logic             dev_we,
  output logic [7:0]       dev_addr,
  output logic [31:0]      dev_wdata,
  input  wire logic        dev_ack,
  input  wire logic [31:0] dev_rdata
);
  import wncs_pkg::*;
  // longword packing of one device byte
  function automatic logic [31:0] lw_of(input logic [7:0] b);
    lw_of = {22'h0, b, 2'b00};
  endfunction
  // lowest set order bit wins
  function automatic wncs_cmd_e cmd_of(input logic [31:0] w);
    if (w[C_INIT]) begin
      cmd_of = WNCS_INIT;
    end else if (w[C_BAT]) begin
      cmd_of = WNCS_BAT;
    end else if (w[C_MEM]) begin
      cmd_of = WNCS_MEM;
    end else if (w[C_CONS]) begin
      cmd_of = WNCS_CONS;
    end else if (w[C_SETUP]) begin
      cmd_of = WNCS_SETUP;
    end else if (w[C_RAW]) begin
      cmd_of = WNCS_RAW;
    end else begin
      cmd_of = WNCS_NONE;
    end
  endfunction
  logic              hreadyout_q;
  logic [31:0]       hrdata_q;
  logic              hresp_q;
  logic              wr_pend_q;
  logic              rd_pend_q;
  logic [7:0]        addr_q;
  logic [31:0]       rd_word;
  logic              acc;
  logic [2:0]        mode_q;
  logic [7:0]        time_q [TIME_REGS];
  logic [7:0]        raw_addr_q;
  logic              raw_we_q;
  logic [7:0]        raw_wdata_q;
  logic [7:0]        raw_rdata_q;
  logic [31:0]       scr_addr_q;
  logic [31:0]       scr_len_q;
  logic              launch_q;
  wncs_cmd_e         launch_cmd_q;
  logic              force_q;
  logic              refused_q;
  wncs_state_e       state_q;
  wncs_cmd_e         cmd_q;
  logic [3:0]        step_q;
  logic              dev_req_q;
  logic              dev_we_q;
  logic [7:0]        dev_addr_q;
  logic [31:0]       dev_wdata_q;
  logic              valid_q;
  logic              init_done_q;
  logic              scr_lock_q;
  logic              kbd_present_q;
  logic [7:0]        kbd_var_q;
  logic              prompt_q;
  logic              op_we;
  logic [7:0]        op_addr;
  logic [7:0]        op_data;
  logic              op_last;
  logic [3:0]        time_idx;
  logic [7:0]        resp_byte;
  assign acc       = hsel && hready && htrans[1];
  assign time_idx  = step_q - 4'd2;
  assign resp_byte = dev_rdata[LW_LSB +: 8];
  // ahb data phase; reads take one wait cycle
  always_ff @(posedge clk) begin
    if (reset) begin
      hreadyout_q <= 1'b1;
      hrdata_q    <= 32'h0;
      hresp_q     <= 1'b0;
      wr_pend_q   <= 1'b0;
      rd_pend_q   <= 1'b0;
      addr_q      <= 8'h00;
    end else if (ce) begin
      wr_pend_q <= acc && hwrite;
      rd_pend_q <= acc && !hwrite;
      if (acc) begin
        addr_q <= haddr[7:0];
      end
      if (acc && !hwrite) begin
        hreadyout_q <= 1'b0;
      end else if (rd_pend_q) begin
        hreadyout_q <= 1'b1;
        hrdata_q    <= rd_word;
      end
    end
  end
  // read decode; unmapped reads zero
  always_comb begin
    rd_word = 32'h0;
    if (addr_q == A_STATUS) begin
      rd_word[S_BUSY]      = (state_q != WNCS_IDLE) || launch_q;
      rd_word[S_VALID]     = valid_q;
      rd_word[S_INIT_DONE] = init_done_q;
      rd_word[S_PROMPT]    = prompt_q;
      rd_word[S_SCR_LOCK]  = scr_lock_q;
      rd_word[S_REFUSED]   = refused_q;
    end else if (addr_q == A_MODE) begin
      rd_word[2:0] = mode_q;
    end else if (addr_q == A_RAW_ADDR) begin
      rd_word = {23'h0, raw_we_q, raw_addr_q};
    end else if (addr_q == A_RAW_WDATA) begin
      rd_word = {24'h0, raw_wdata_q};
    end else if (addr_q == A_RAW_RDATA) begin
      rd_word = {24'h0, raw_rdata_q};
    end else if (addr_q == A_SCR_ADDR) begin
      rd_word = scr_addr_q;
    end else if (addr_q == A_SCR_LEN) begin
      rd_word = scr_len_q;
    end else if (addr_q >= A_TIME0 && addr_q < A_TIME0 + 8'(TIME_REGS) * A_WORD_STEP) begin
      rd_word = {24'h0, time_q[3'((addr_q - A_TIME0) >> 2)]};
    end
  end
  // software register writes
  always_ff @(posedge clk) begin
    if (reset) begin
      mode_q      <= 3'h0;
      raw_addr_q  <= 8'h00;
      raw_we_q    <= 1'b0;
      raw_wdata_q <= 8'h00;
      scr_addr_q  <= 32'h0;
      scr_len_q   <= 32'h0;
      for (int i = 0; i < TIME_REGS; i++) begin
        time_q[i] <= 8'h00;
      end
    end else if (ce && wr_pend_q) begin
      if (addr_q == A_MODE) begin
        mode_q <= hwdata[2:0];
      end else if (addr_q == A_RAW_ADDR) begin
        raw_addr_q <= hwdata[7:0];
        raw_we_q   <= hwdata[RAW_WRITE_BIT];
      end else if (addr_q == A_RAW_WDATA) begin
        raw_wdata_q <= hwdata[7:0];
      end else if (addr_q == A_SCR_ADDR) begin
        scr_addr_q <= hwdata;
      end else if (addr_q == A_SCR_LEN) begin
        scr_len_q <= hwdata;  // see R17
      end else if (addr_q >= A_TIME0 && addr_q < A_TIME0 + 8'(TIME_REGS) * A_WORD_STEP) begin
        time_q[3'((addr_q - A_TIME0) >> 2)] <= hwdata[7:0];
      end
    end
  end
  // order launch; orders while busy are refused
  always_ff @(posedge clk) begin
    if (reset) begin
      launch_q     <= 1'b0;
      launch_cmd_q <= WNCS_NONE;
      force_q      <= 1'b0;
      refused_q    <= 1'b0;
    end else if (ce) begin
      if (wr_pend_q && addr_q == A_CTRL && cmd_of(hwdata) != WNCS_NONE) begin
        if (launch_q || state_q != WNCS_IDLE) begin
          refused_q <= 1'b1;
        end else begin
          launch_q     <= 1'b1;
          launch_cmd_q <= cmd_of(hwdata);
          force_q      <= hwdata[C_FORCE];
          refused_q    <= 1'b0;
        end
      end else if (state_q == WNCS_IDLE) begin
        launch_q <= 1'b0;
      end
    end
  end
  // operation for current command and step
  always_comb begin
    op_we   = 1'b1;
    op_addr = D_CSRD;
    op_data = BYTE_ZERO;
    op_last = 1'b1;
    case (cmd_q)
      WNCS_INIT: begin
        op_last = (step_q == INIT_LAST);
        if (step_q == 4'd0) begin
          op_we   = 1'b0;  // see R1
          op_addr = D_CSRD;
        end else if (step_q == 4'd1) begin
          op_addr = D_CSRB;
          op_data = {CSRB_INHIBIT, CSRB_IRQ_OFF, mode_q};  // see R2
        end else if (step_q < INIT_LAST - 4'd1) begin
          op_addr = D_TIME[time_idx[2:0]];  // see R3
          op_data = time_q[time_idx[2:0]];
        end else if (step_q == INIT_LAST - 4'd1) begin
          op_addr = D_CSRA;
          op_data = {1'b0, CSRA_DIVIDER, CSRA_RATE};  // see R4
        end else begin
          op_addr = D_CSRB;
          op_data = {~CSRB_INHIBIT, CSRB_IRQ_OFF, mode_q};  // see R5
        end
      end
      WNCS_BAT: begin
        // check bytes, boot device, boot flags are contiguous
        op_last = (step_q == BAT_LAST);
        op_addr = D_BATCHK + {4'h0, step_q};
        if (step_q < 4'd4) begin
          op_data = BAT_PAT[step_q[1:0]];  // see R6
        end else begin
          op_data = BYTE_ZERO;  // see R8, R9, R7
        end
      end
      WNCS_MEM: begin
        op_addr = D_KBD;
        op_data = BYTE_ZERO;  // see R11
      end
      WNCS_CONS: begin
        op_we   = 1'b0;
        op_last = (step_q == 4'd2);
        if (step_q == 4'd0) begin
          op_addr = D_CONSOLE_FLAGS;
        end else if (step_q == 4'd1) begin
          op_addr = D_KBD;
        end else begin
          op_addr = D_CONSID;
        end
      end
      WNCS_SETUP: begin
        op_last = (step_q == SETUP_LAST);
        if (step_q < SETUP_LEN0) begin
          op_addr = D_SCR + {4'h0, step_q};
          op_data = scr_addr_q[8 * step_q[1:0] +: 8];
        end else if (step_q < SETUP_LAST) begin
          op_addr = D_SCRLEN + {4'h0, step_q - SETUP_LEN0};
          op_data = scr_len_q[8 * step_q[1:0] +: 8];  // see R17
        end else begin
          op_addr = D_TAPE;
          op_data = BYTE_ZERO;  // see R18
        end
      end
      WNCS_RAW: begin
        op_we   = raw_we_q;
        op_addr = raw_addr_q;
        op_data = raw_wdata_q;
      end
      default: begin
        op_we = 1'b0;
      end
    endcase
  end
  // sequencer and device port
  always_ff @(posedge clk) begin
    if (reset) begin
      state_q     <= WNCS_IDLE;
      cmd_q       <= WNCS_NONE;
      step_q      <= 4'd0;
      dev_req_q   <= 1'b0;
      dev_we_q    <= 1'b0;
      dev_addr_q  <= 8'h00;
      dev_wdata_q <= 32'h0;
    end else if (ce) begin
      case (state_q)
        WNCS_IDLE: begin
          if (launch_q) begin
            cmd_q <= launch_cmd_q;
            // scratch address goes out only once
            step_q <= (launch_cmd_q == WNCS_SETUP && scr_lock_q) ? SETUP_LEN0 : 4'd0;  // see R15
            state_q <= WNCS_LOAD;
          end
        end
        WNCS_LOAD: begin
          dev_req_q   <= 1'b1;
          dev_we_q    <= op_we;
          dev_addr_q  <= op_addr;
          dev_wdata_q <= lw_of(op_data);  // see R20
          state_q     <= WNCS_WAIT;
        end
        WNCS_WAIT: begin
          if (dev_ack) begin
            dev_req_q <= 1'b0;
            // valid chip and no force ends init early
            if (op_last || (cmd_q == WNCS_INIT && step_q == 4'd0 && dev_rdata[LW_VALID_BIT] && !force_q)) begin
              state_q <= WNCS_IDLE;  // see R1
              cmd_q   <= WNCS_NONE;
            end else begin
              step_q  <= step_q + 4'd1;
              state_q <= WNCS_LOAD;
            end
          end
        end
        default: begin
          state_q <= WNCS_IDLE;
        end
      endcase
    end
  end
  // results gathered from device answers
  always_ff @(posedge clk) begin
    if (reset) begin
      valid_q       <= 1'b0;
      init_done_q   <= 1'b0;
      scr_lock_q    <= 1'b0;
      kbd_present_q <= 1'b0;
      kbd_var_q     <= 8'h00;
      prompt_q      <= 1'b0;
      raw_rdata_q   <= 8'h00;
    end else if (ce && state_q == WNCS_WAIT && dev_ack) begin
      case (cmd_q)
        WNCS_INIT: begin
          if (step_q == 4'd0) begin
            valid_q     <= dev_rdata[LW_VALID_BIT];
            init_done_q <= 1'b0;
          end
          if (op_last) begin
            init_done_q <= 1'b1;
          end
        end
        WNCS_CONS: begin
          if (step_q == 4'd0) begin
            kbd_present_q <= dev_rdata[LW_KBD_PRESENT];  // see R19
          end else if (step_q == 4'd1) begin
            kbd_var_q <= resp_byte;  // see R10
          end else begin
            // only the built-in display uses the variant
            prompt_q <= (resp_byte == CONS_BITMAP)
                        && (!kbd_present_q || kbd_var_q > KBD_MAX);  // see R12, R13, R14
          end
        end
        WNCS_SETUP: begin
          if (step_q == SETUP_LEN0 - 4'd1) begin
            scr_lock_q <= 1'b1;  // see R15
          end
        end
        WNCS_RAW: begin
          if (!dev_we_q) begin
            raw_rdata_q <= resp_byte;  // see R16, R20
          end
        end
        default: ;
      endcase
    end
  end

  assign hreadyout = hreadyout_q;
  assign hrdata    = hrdata_q;
  assign hresp     = hresp_q;
  assign dev_req   = dev_req_q;
  assign dev_we    = dev_we_q;
  assign dev_addr  = dev_addr_q;
  assign dev_wdata = dev_wdata_q;
endmodule
`default_nettype wire

/* File: dv/wncs_dev_model.sv */
// Purpose: watch chip register port model
// Assumes: byte array indexed by device byte index
// Notes:   delay sets ack latency
`timescale 1ns/1ps
`default_nettype none
module wncs_dev_model (
  // clock and reset
  input  wire logic        clk,
  input  wire logic        reset,
  // register port
  input  wire logic        dev_req,
  input  wire logic        dev_we,
  input  wire logic [7:0]  dev_addr,
  input  wire logic [31:0] dev_wdata,
  output logic             dev_ack,
  output logic [31:0]      dev_rdata,
  // answer delay
  input  wire logic [3:0]  delay
);
  logic [7:0] mem [64];
  logic [3:0] cnt_q;
  initial begin
    dev_ack = 1'h0;
    dev_rdata = 32'h0;
    cnt_q = 4'h0;
  end
  always @(posedge clk) begin
    dev_ack <= 1'h0;
    dev_rdata <= ~dev_rdata;
    if (reset) begin
      cnt_q <= 4'h0;
    end else if (dev_req && !dev_ack) begin
      if (cnt_q >= delay) begin
        cnt_q <= 4'h0;
        dev_ack <= 1'h1;
        dev_rdata <= {22'h0, mem[dev_addr[5:0]], 2'h0};
        if (dev_we) begin
          mem[dev_addr[5:0]] <= dev_wdata[9:2];
        end
      end else begin
        cnt_q <= cnt_q + 4'h1;
      end
    end
  end
endmodule
`default_nettype wire

/* File: dv/wncs_ctrl_asserts.sv */
// Purpose: port checker for the console store controller
// Assumes: ce held high
// Notes:   bound below
`timescale 1ns/1ps
`default_nettype none
module wncs_ctrl_asserts
  import wncs_pkg::*;
(
  // clock and reset
  input wire logic        clk,
  input wire logic        reset,
  input wire logic        ce,
  // ahb-lite
  input wire logic        hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0]  htrans,
  input wire logic        hwrite,
  input wire logic [2:0]  hsize,
  input wire logic        hready,
  input wire logic [31:0] hwdata,
  input wire logic        hreadyout,
  input wire logic [31:0] hrdata,
  input wire logic        hresp,
  // device port
  input wire logic        dev_req,
  input wire logic        dev_we,
  input wire logic [7:0]  dev_addr,
  input wire logic [31:0] dev_wdata,
  input wire logic        dev_ack,
  input wire logic [31:0] dev_rdata
);
  import wncs_pkg::*;
  default clocking @(posedge clk); endclocking
  default disable iff (reset);
  logic take;
  logic dwr;
  assign take = hsel && hready && htrans[1] && ce;
  assign dwr  = dev_req && dev_we;
  AST_RD_WAIT: assert property (take && !hwrite |=> !hreadyout ##1 hreadyout)
    else $error("read wait state wrong");
  AST_WR_NOWAIT: assert property (take && hwrite |=> hreadyout)
    else $error("write stalled");
  AST_HRESP: assert property (hresp == 1'h0)
    else $error("response not okay");
  AST_REQ_HOLD: assert property (dev_req && !dev_ack |=> dev_req && $stable(dev_addr) && $stable(dev_we))
    else $error("request changed before ack");
  AST_REQ_DROP: assert property (dev_req && dev_ack |=> !dev_req)
    else $error("request held after ack");
  AST_WDATA_CLEAN: assert property (dwr |-> dev_wdata[31:10] == 22'h0 && dev_wdata[1:0] == 2'h0)
    else $error("stray write data bits");
  AST_CSRB_IRQ: assert property (dwr && dev_addr == D_CSRB |-> dev_wdata[8:5] == CSRB_IRQ_OFF)
    else $error("control b enables not off");
  AST_CSRA_BASE: assert property (dwr && dev_addr == D_CSRA |-> dev_wdata[9:2] == 8'h20)
    else $error("control a time base wrong");
  AST_BAT_PAT: assert property (dwr && dev_addr inside {[8'h1E:8'h21]} |->
    dev_wdata[9:2] == BAT_PAT[2'(dev_addr - D_BATCHK)])
    else $error("battery pattern wrong");
  AST_BOOT_ZERO: assert property (dwr && dev_addr inside {[8'h22:8'h29]} |-> dev_wdata[9:2] == 8'h00)
    else $error("boot byte not zero");
  AST_TAPE_ZERO: assert property (dwr && dev_addr == D_TAPE |-> dev_wdata[4:2] == 3'h0)
    else $error("tape tape_a not zero");
  cover property (take && !hwrite);
  cover property (dwr && dev_addr == D_CSRA);
  cover property (dwr && dev_addr == D_BATCHK);
  cover property (dwr && dev_addr == D_TAPE);
endmodule
bind wncs_ctrl wncs_ctrl_asserts u_chk (.clk, .reset, .ce, .hsel, .haddr, .htrans, .hwrite, .hsize, .hready,
  .hwdata, .hreadyout, .hrdata, .hresp, .dev_req, .dev_we, .dev_addr, .dev_wdata, .dev_ack, .dev_rdata);
`default_nettype wire

/* File: dv/wncs_ctrl_tb_top.sv */
// Purpose: self-checking bench for the console store controller
// Assumes: one ahb master, device model on the far side
// Notes:   expected reads and device writes queued
`timescale 1ns/1ps
`default_nettype none
module wncs_ctrl_tb_top;
  import wncs_pkg::*;
  logic        clk;
  logic        reset;
  logic        hsel;
  logic [31:0] haddr;
  logic [1:0]  htrans;
  logic        hwrite;
  logic [31:0] hwdata;
  logic        hreadyout;
  logic [31:0] hrdata;
  logic        hresp;
  logic        dev_req;
  logic        dev_we;
  logic [7:0]  dev_addr;
  logic [31:0] dev_wdata;
  logic        dev_ack;
  logic [31:0] dev_rdata;
  logic [3:0]  dly;
  logic [31:0] seed;
  logic        rd_pend;
  logic [2:0]  md;
  logic [7:0]  tv [7];
  logic [7:0]  ty [7] = '{8'hB0, 8'hB0, 8'hB0, 8'hB0, 8'h02, 8'h01, 8'h00};
  logic        pr [7] = '{1'h1, 1'h0, 1'h1, 1'h1, 1'h0, 1'h0, 1'h1};
  logic [7:0]  vr [7] = '{8'h00, 8'h03, 8'h10, 8'h0F, 8'h10, 8'hFF, 8'h20};
  int          num_errors;
  int          check_count;
  int          wr_cnt;
  logic [31:0] exp_q [$];
  logic [31:0] msk_q [$];
  logic [15:0] wexp_q [$];
  wncs_ctrl dut (.clk, .reset, .ce(1'h1), .hsel, .haddr, .htrans, .hwrite, .hsize(3'h2), .hready(hreadyout),
    .hwdata, .hreadyout, .hrdata, .hresp, .dev_req, .dev_we, .dev_addr, .dev_wdata, .dev_ack, .dev_rdata);
  wncs_dev_model dev (.clk, .reset, .dev_req, .dev_we, .dev_addr, .dev_wdata, .dev_ack, .dev_rdata, .delay(dly));
  always #5 clk = ~clk;
  function automatic logic [31:0] xs();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    check_count++;
    if (seen !== exp) begin
      num_errors++;
      $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task automatic stop_test();
    $display("errors=%0d checks=%0d", num_errors, check_count);
    if (num_errors == 0 && check_count > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask
  task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
    hsel <= 1'h1;
    haddr <= {24'h0, a};
    hwrite <= w;
    htrans <= 2'h2;
    do @(posedge clk); while (!hreadyout);
    htrans <= 2'h0;
    hwdata <= d;
    do @(posedge clk); while (!hreadyout);
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    bus(1'h1, a, d);
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] e, input logic [31:0] m, output logic [31:0] d);
    exp_q.push_back(e);
    msk_q.push_back(m);
    bus(1'h0, a, 32'h0);
    d = hrdata;
  endtask
  task automatic st(input logic [31:0] e, input logic [31:0] m);
    logic [31:0] d;
    rd(A_STATUS, e, m, d);
  endtask
  task automatic order(input logic [31:0] m);
    logic [31:0] s;
    int n;
    n = 0;
    s = 32'h1;
    wr(A_CTRL, m);
    while (s[S_BUSY] && n < 400) begin
      rd(A_STATUS, 32'h0, 32'h0, s);
      n++;
    end
    if (s[S_BUSY]) begin
      num_errors++;
    end
  endtask
  task automatic ew(input logic [7:0] a, input logic [7:0] b);
    wexp_q.push_back({a, b});
  endtask
  task automatic init_exp();
    ew(D_CSRB, {1'h1, 4'h0, md});
    for (int i = 0; i < 7; i++) begin
      ew(D_TIME[i], tv[i]);
    end
    ew(D_CSRA, 8'h20);
    ew(D_CSRB, {1'h0, 4'h0, md});
  endtask
  task automatic bat_exp();
    for (int i = 0; i < 12; i++) begin
      ew(D_BATCHK + 8'(i), (i < 4) ? BAT_PAT[i] : 8'h00);
    end
  endtask
  task automatic len_exp(input logic [31:0] l);
    for (int i = 0; i < 4; i++) begin
      ew(D_SCRLEN + 8'(i), l[8*i +: 8]);
    end
    ew(D_TAPE, 8'h00);
  endtask
  task automatic peek(input logic [7:0] i, input logic [7:0] e);
    logic [31:0] d;
    wr(A_RAW_ADDR, {24'h0, i});
    order(32'h1 << C_RAW);
    rd(A_RAW_RDATA, {24'h0, e}, 32'hFF, d);
  endtask
  always @(posedge clk) begin
    if (rd_pend && hreadyout) begin
      rd_pend = 1'h0;
      if (msk_q[0] != 32'h0) begin
        check(hrdata & msk_q[0], exp_q[0] & msk_q[0]);
      end
      void'(exp_q.pop_front());
      void'(msk_q.pop_front());
    end
    if (hsel && hreadyout && htrans[1] && !hwrite) begin
      rd_pend = 1'h1;
    end
    if (dev_req && dev_ack && dev_we) begin
      wr_cnt++;
      if (wexp_q.size() > 0) begin
        check({16'h0, dev_addr, dev_wdata[9:2]}, {16'h0, wexp_q.pop_front()});
      end else begin
        check({16'h0, dev_addr, dev_wdata[9:2]}, 32'hFFFF0000);
      end
    end
  end
  initial begin
    #500000;
    num_errors++;
    stop_test();
  end
  initial begin
    logic [31:0] d;
    logic [31:0] a;
    logic [31:0] l;
    int n0;
    clk = 1'h0;
    reset = 1'h1;
    hsel = 1'h0;
    haddr = 32'h0;
    htrans = 2'h0;
    hwrite = 1'h0;
    hwdata = 32'h0;
    dly = 4'h2;
    seed = 32'h27;
    rd_pend = 1'h0;
    num_errors = 0;
    check_count = 0;
    wr_cnt = 0;
    for (int i = 0; i < 64; i++) begin
      dev.mem[i] = 8'(xs());
    end
    repeat (16) @(posedge clk);
    reset <= 1'h0;
    @(posedge clk);
    st(32'h0, 32'h3F);
    rd(A_CTRL, 32'h0, 32'hFFFFFFFF, d);
    rd(8'h3C, 32'h0, 32'hFFFFFFFF, d);
    md = 3'(xs());
    wr(A_MODE, {29'h0, md});
    for (int i = 0; i < 7; i++) begin
      tv[i] = 8'(xs());
      wr(8'(A_TIME0 + i * 4), {24'h0, tv[i]});
    end
    dev.mem[D_CSRD[5:0]] = 8'h00;
    init_exp();
    order(32'h1);
    st(32'h4, 32'h7);
    dev.mem[D_CSRD[5:0]] = 8'h80;
    n0 = wr_cnt;
    order(32'h1);
    check(32'(wr_cnt - n0), 32'h0);
    st(32'h2, 32'h2);
    init_exp();
    order(32'h3);
    st(32'h4, 32'h4);
    dly <= 4'h0;
    bat_exp();
    order(32'h1 << C_BAT);
    dev.mem[D_KBD[5:0]] = 8'h09;
    ew(D_KBD, 8'h00);
    order(32'h1 << C_MEM);
    peek(D_KBD, 8'h00);
    vr[0] = 8'(xs()) & 8'h0F;
    for (int i = 0; i < 7; i++) begin
      dev.mem[D_CONSOLE_FLAGS[5:0]] = {1'h0, pr[i], 6'h0};
      dev.mem[D_KBD[5:0]] = vr[i];
      dev.mem[D_CONSID[5:0]] = ty[i];
      order(32'h1 << C_CONS);
      st({28'h0, (ty[i] == 8'hB0 && (!pr[i] || vr[i] > 8'h0F)), 3'h0}, 32'h8);
    end
    a = xs();
    l = xs();
    wr(A_SCR_ADDR, a);
    wr(A_SCR_LEN, l);
    rd(A_SCR_LEN, l, 32'hFFFFFFFF, d);
    for (int i = 0; i < 4; i++) begin
      ew(D_SCR + 8'(i), a[8*i +: 8]);
    end
    len_exp(l);
    order(32'h1 << C_SETUP);
    st(32'h10, 32'h10);
    wr(A_SCR_ADDR, ~a);
    len_exp(l);
    n0 = wr_cnt;
    order(32'h1 << C_SETUP);
    check(32'(wr_cnt - n0), 32'h5);
    d = xs();
    wr(A_RAW_ADDR, (32'h1 << RAW_WRITE_BIT) | 32'h12);
    wr(A_RAW_WDATA, {24'h0, d[7:0]});
    ew(8'h12, d[7:0]);
    order(32'h1 << C_RAW);
    peek(8'h12, d[7:0]);
    dly <= 4'hF;
    dev.mem[D_KBD[5:0]] = 8'h05;
    bat_exp();
    wr(A_CTRL, 32'h1 << C_BAT);
    wr(A_CTRL, 32'h1 << C_MEM);
    st(32'h21, 32'h21);
    order(32'h0);
    dly <= 4'h1;
    peek(D_KBD, 8'h05);
    st(32'h0, 32'h20);
    check(wexp_q.size(), 32'h0);
    stop_test();
  end
endmodule
`default_nettype wire
